//--- verilog/scd_clock_control.sv
// System clock source select, divider control and bank-5 mux bus timing
`timescale 1ns/1ps
module scd_clock_control
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic clock_source_select_pin,
    input wire logic external_clock_input,
    output logic undivided_internal_clock,
    output logic system_clock,
    output logic cpu_clock_en,
    output logic periph_clock_en,
    output logic test_mode,
    input wire logic rom5_chip_select,
    input wire logic rom5_wait_n,
    output logic rom5_addr_phase,
    output logic rom5_wait_stall
);
    import scd_pkg::*;

    // Byte-lane merge for control register writes, the only writable register
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    scd_div_if dif ();

    // ---------------- Avalon slave, one wait state ----------------
    logic ack_q;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] rdata_q;
    logic [31:0] status_w;
    wire req = avs_read || avs_write;
    wire sel_ctrl = (avs_address == CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET);
    wire sel_stat = (avs_address == CLOCK_STATUS_OFFSET);
    wire wr_ctrl = avs_write && ack_q && sel_ctrl;
    assign ctrl_d = wr_ctrl ? (be_merge(ctrl_q, avs_writedata, avs_byteenable)
                               & CTRL_WRITABLE_MASK) : ctrl_q;
    wire [31:0] rd_mux = sel_ctrl ? ctrl_q : (sel_stat ? status_w : 32'h0000_0000);
    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata = rdata_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
            ctrl_q <= CLOCK_DIVIDE_AND_MUX_CONTROL_RESET;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req && !ack_q;
            ctrl_q <= ctrl_d;
            if (avs_read && !ack_q)
            begin
                rdata_q <= rd_mux;
            end
        end
    end

    wire [DIV_W-1:0] div_field = ctrl_q[DIV_LSB +: DIV_W];
    wire wait_en = ctrl_q[WAIT_EN_BIT];
    // mux enable steers the bus timing
    wire mux_en = ctrl_q[MUX_EN_BIT];
    wire [ADDR_CYC_W-1:0] addr_cyc = ctrl_q[ADDR_CYC_LSB +: ADDR_CYC_W];
    assign test_mode = ctrl_q[TEST_BIT];

    // ---------------- PLL model: external period split into factor ticks ----------------
    logic ext_q;
    logic [PERIOD_W-1:0] cyc_q;
    logic [PERIOD_W-1:0] period_q;
    logic [PERIOD_W-1:0] phase_q;
    logic [2:0] nt_q;
    logic lock_q;
    wire ext_rise = external_clock_input && !ext_q;
    wire [PERIOD_W-1:0] step = PERIOD_W'(period_q / PERIOD_W'(PLL_MULTIPLY_FACTOR));
    wire step_ok = lock_q && (step != '0);
    wire phase_end = step_ok && (phase_q >= step - 16'h0001) && (nt_q < PLL_FACTOR_M1);
    wire pll_tick = step_ok && (ext_rise || phase_end);
    wire pll_level = step_ok && (phase_q < (step >> 1));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_q <= 1'b0;
            cyc_q <= '0;
            period_q <= '0;
            phase_q <= '0;
            nt_q <= '0;
            lock_q <= 1'b0;
        end
        else
        begin
            ext_q <= external_clock_input;
            if (ext_rise)
            begin
                period_q <= cyc_q + 16'h0001;
                // First edge after reset measures a partial period, so lock waits for the second
                lock_q <= (period_q != '0);
                cyc_q <= '0;
                phase_q <= '0;
                nt_q <= '0;
            end
            else
            begin
                cyc_q <= (cyc_q == PERIOD_MAX) ? cyc_q : cyc_q + 16'h0001;
                phase_q <= phase_end ? '0 : phase_q + 16'h0001;
                nt_q <= phase_end ? nt_q + 3'h1 : nt_q;
            end
        end
    end

    // ---------------- Source select and divider ----------------
    // pin picks source
    wire src_tick = clock_source_select_pin ? ext_rise : pll_tick;
    wire src_level = clock_source_select_pin ? external_clock_input : pll_level;
    assign dif.src_tick = src_tick;
    assign dif.src_level = src_level;
    assign dif.div_sel = div_field;
    assign undivided_internal_clock = src_level;

    scd_divider u_div
    (
        .clk(clk),
        .rst(rst),
        .dv(dif.div)
    );

    // divided clock to core and peripherals
    assign cpu_clock_en = dif.sys_tick;
    assign periph_clock_en = dif.sys_tick;
    assign system_clock = dif.sys_level;
    wire mclk_tick = dif.sys_tick;

    // ---------------- Bank-5 address phase and wait check ----------------
    scd_bus_state_t st_q;
    scd_bus_state_t st_d;
    logic [1:0] ac_q;
    logic [1:0] ac_d;
    logic cs_q;
    logic wpend_q;
    logic stall_q;
    wire cs_rise = rom5_chip_select && !cs_q;
    // Code 11 is undefined; it is held to the longest defined phase
    wire [1:0] ac_last = (addr_cyc == 2'b11) ? 2'b10 : addr_cyc;

    always_comb
    begin
        st_d = st_q;
        ac_d = ac_q;
        unique case (st_q)
            SCD_IDLE:
            begin
                ac_d = 2'b00;
                if (cs_rise)
                begin
                    st_d = mux_en ? SCD_ADDR : SCD_DATA;
                end
            end
            SCD_ADDR:
            begin
                if (!rom5_chip_select)
                begin
                    st_d = SCD_IDLE;
                end
                else if (mclk_tick && ac_q == ac_last)
                begin
                    st_d = SCD_DATA;
                end
                else if (mclk_tick)
                begin
                    ac_d = ac_q + 2'b01;
                end
            end
            SCD_DATA:
            begin
                if (!rom5_chip_select)
                begin
                    st_d = SCD_IDLE;
                end
            end
            default:
            begin
                st_d = SCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= SCD_IDLE;
            ac_q <= 2'b00;
            cs_q <= 1'b0;
            wpend_q <= 1'b0;
            stall_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ac_q <= ac_d;
            cs_q <= rom5_chip_select;
            // sample wait on the first memory clock enable after select
            wpend_q <= rom5_chip_select && wait_en && (cs_rise || (wpend_q && !mclk_tick));
            if (!rom5_chip_select || !wait_en)
            begin
                stall_q <= 1'b0;
            end
            else if ((wpend_q || stall_q) && mclk_tick)
            begin
                stall_q <= !rom5_wait_n;
            end
        end
    end

    assign rom5_addr_phase = (st_q == SCD_ADDR);
    assign rom5_wait_stall = stall_q;

    always_comb
    begin
        status_w = 32'h0000_0000;
        status_w[ST_SRC_SEL_BIT] = clock_source_select_pin;
        status_w[ST_PLL_LOCK_BIT] = lock_q;
        status_w[ST_ADDR_PHASE_BIT] = rom5_addr_phase;
        status_w[ST_WAIT_STALL_BIT] = stall_q;
        status_w[ST_SYS_LEVEL_BIT] = dif.sys_level;
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_pll_source: assert property (!clock_source_select_pin |-> (src_tick == pll_tick))
        else $error("PLL not used as source with select low");
    chk_ext_source: assert property (clock_source_select_pin && ext_rise
        |-> src_tick)
        else $error("external edge not passed with select high");
    chk_div_four: assert property ((div_field == 16'h0004 && $stable(div_field)
        && cpu_clock_en) |=> !cpu_clock_en)
        else $error("divide by four gave adjacent system ticks");
    chk_undiv_level: assert property (div_field == 16'h0000
        |-> system_clock == undivided_internal_clock)
        else $error("undivided system clock differs from source");
    chk_core_periph: assert property ((cpu_clock_en || periph_clock_en)
        |-> (cpu_clock_en == periph_clock_en && src_tick))
        else $error("core and peripheral enables disagree");
    chk_wait_disabled: assert property (!wait_en |=> !rom5_wait_stall)
        else $error("wait stall raised with wait checking off");
    chk_addr_one: assert property ((rom5_addr_phase && addr_cyc == 2'b00 && mclk_tick
        && rom5_chip_select && $stable(addr_cyc)) |=> !rom5_addr_phase)
        else $error("address phase outlived one memory clock");
    chk_pll_factor: assert property (nt_q <= PLL_FACTOR_M1)
        else $error("PLL model exceeded its factor");
    chk_reserved_zero: assert property (ctrl_q[30:20] == 11'h000)
        else $error("reserved control bits not zero");

    cov_ctrl_write: cover property (wr_ctrl);
    cov_addr_three: cover property (rom5_addr_phase && addr_cyc == 2'b10);
    cov_wait_stall: cover property (rom5_wait_stall);
    cov_pll_lock: cover property (lock_q && !clock_source_select_pin && cpu_clock_en);
endmodule

//--- pkg/scd_pkg.sv
// Constants and types for the system clock divider and bank-5 mux control
package scd_pkg;
    // Register map, byte addresses
    localparam logic [15:0] CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET = 16'h3000;
    localparam logic [15:0] CLOCK_STATUS_OFFSET = 16'h3040;
    localparam logic [31:0] CLOCK_DIVIDE_AND_MUX_CONTROL_RESET = 32'h0000_0000;
    // Control field positions
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 16;
    localparam int WAIT_EN_BIT = 16;
    localparam int MUX_EN_BIT = 17;
    localparam int ADDR_CYC_LSB = 18;
    localparam int ADDR_CYC_W = 2;
    localparam int TEST_BIT = 31;
    // Bits that hold storage; the rest read as zero
    localparam logic [31:0] CTRL_WRITABLE_MASK = 32'h800f_ffff;
    // Status field positions
    localparam int ST_SRC_SEL_BIT = 0;
    localparam int ST_PLL_LOCK_BIT = 1;
    localparam int ST_ADDR_PHASE_BIT = 2;
    localparam int ST_WAIT_STALL_BIT = 3;
    localparam int ST_SYS_LEVEL_BIT = 4;
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PLL_MULTIPLY_FACTOR = 5;
    localparam int PERIOD_W = 16;
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = 16'hffff;
    localparam logic [2:0] PLL_FACTOR_M1 = 3'h4;
    typedef enum logic [1:0] {
        SCD_IDLE = 2'b00,
        SCD_ADDR = 2'b01,
        SCD_DATA = 2'b11
    } scd_bus_state_t;
endpackage

//--- pkg/scd_div_if.sv
// Carrier between the clock control top and its power-of-two divider
`timescale 1ns/1ps
interface scd_div_if;
    import scd_pkg::*;
    logic src_tick;
    logic src_level;
    logic [DIV_W-1:0] div_sel;
    logic sys_tick;
    logic sys_level;
    modport ctrl (output src_tick, output src_level, output div_sel,
                  input sys_tick, input sys_level);
    modport div (input src_tick, input src_level, input div_sel,
                 output sys_tick, output sys_level);
endinterface

//--- verilog/scd_divider.sv
// Power-of-two divider of the undivided internal clock enable
`timescale 1ns/1ps
module scd_divider
(
    input wire logic clk,
    input wire logic rst,
    scd_div_if.div dv
);
    import scd_pkg::*;

    // Highest set bit wins if software breaks the one-hot rule
    function automatic logic [DIV_W-1:0] div_limit(input logic [DIV_W-1:0] sel);
        logic [DIV_W-1:0] lim;
        lim = '0;
        for (int i = 0; i < DIV_W; i++)
        begin
            if (sel[i])
            begin
                lim = DIV_W'((32'h1 << i) - 32'h1);
            end
        end
        return lim;
    endfunction

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic level_q;
    logic level_d;
    wire [DIV_W-1:0] limit = div_limit(dv.div_sel);
    wire undivided = (dv.div_sel == '0);
    wire at_limit = (cnt_q >= limit);

    assign cnt_d = !dv.src_tick ? cnt_q : (at_limit ? '0 : cnt_q + 16'h0001);
    assign dv.sys_tick = dv.src_tick && (undivided || at_limit);
    assign level_d = dv.src_tick ? dv.sys_tick : level_q;
    assign dv.sys_level = undivided ? dv.src_level : level_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            level_q <= level_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_div_two_spacing: assert property ((dv.div_sel == 16'h0002 && $stable(dv.div_sel)
        && dv.sys_tick) |-> !(dv.src_tick && dv.sys_tick && cnt_q == 16'h0000))
        else $error("divide by two produced back to back source ticks");
    chk_undiv_pass: assert property (undivided |-> (dv.sys_tick == dv.src_tick))
        else $error("undivided setting dropped a source tick");
endmodule

//--- tb/scd_partner.sv
// External clock source and bank-5 wait-driving device model
`timescale 1ns/1ps
module scd_partner
#(
    parameter int HALF = 10
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs,
    input wire logic [7:0] wait_len,
    output logic ext_clk,
    output logic wait_n
);
    int hc;
    int wc;
    logic cs_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_clk <= 1'b0;
            hc <= 0;
        end
        else if (hc == HALF - 1)
        begin
            hc <= 0;
            ext_clk <= ~ext_clk;
        end
        else
            hc <= hc + 1;
    end
    // Wait held after select rises; released line pulls high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cs_q <= 1'b0;
            wc <= 0;
        end
        else
        begin
            cs_q <= cs;
            if (cs && !cs_q)
                wc <= int'(wait_len);
            else if (wc != 0)
                wc <= wc - 1;
        end
    end
    assign wait_n = !(cs && wc != 0);
endmodule

//--- tb/scd_clock_control_tb_top.sv
// Register-driven bench for the clock control block
`timescale 1ns/1ps
module scd_clock_control_tb_top;
    import scd_pkg::*;
    logic clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic sel, ext_clk, uclk, sclk, cpu_en, per_en, test_mode, cs, wait_n, aph, stall;
    logic [7:0] wait_len;
    int err_total, n_checks, gap, hcnt, na, ne, ns;
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    scd_partner #(.HALF(10)) far (.clk(clk), .rst(rst), .cs(cs), .wait_len(wait_len),
        .ext_clk(ext_clk), .wait_n(wait_n));
    scd_clock_control uut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .clock_source_select_pin(sel),
        .external_clock_input(ext_clk), .undivided_internal_clock(uclk),
        .system_clock(sclk), .cpu_clock_en(cpu_en), .periph_clock_en(per_en),
        .test_mode(test_mode), .rom5_chip_select(cs), .rom5_wait_n(wait_n),
        .rom5_addr_phase(aph), .rom5_wait_stall(stall));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic expire(input int i);
        if (i >= 2000)
        begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        expire(i);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Gap in cycles between two enables, and system clock high time inside it
    task automatic meas();
        int i;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge clk);
            if (cpu_en === 1'b1 && i > 0)
                break;
        end
        expire(i);
        gap = 0;
        hcnt = 0;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge clk);
            gap++;
            if (sclk === 1'b1)
                hcnt++;
            if (cpu_en === 1'b1)
                break;
        end
        expire(i);
        chk({31'h0, per_en}, {31'h0, cpu_en});
    endtask
    // Select pulse; counts phase cycles, enables inside phase, stall cycles
    task automatic cs_pulse();
        @(posedge clk);
        cs <= 1'b1;
        na = 0;
        ne = 0;
        ns = 0;
        repeat (60)
        begin
            @(posedge clk);
            if (aph === 1'b1)
            begin
                na++;
                if (cpu_en === 1'b1)
                    ne++;
            end
            if (stall === 1'b1)
                ns++;
        end
        cs <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    initial
    begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 16'h0;
        avs_writedata = 32'h0;
        sel = 1'b1;
        cs = 1'b0;
        wait_len = 8'h0;
        err_total = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET, CLOCK_DIVIDE_AND_MUX_CONTROL_RESET);
        acc(1'b1, 16'h3010, 32'hffff_ffff);
        rdc(16'h3010, 32'h0);
        acc(1'b1, CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET, 32'hffff_ffff);
        rdc(CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET, CTRL_WRITABLE_MASK);
        chk({31'h0, test_mode}, 32'h1);
        acc(1'b1, CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET, 32'h0);
        // Write lands at the answering edge; the output shows it one edge later
        @(posedge clk);
        chk({31'h0, test_mode}, 32'h0);
        acc(1'b1, CLOCK_STATUS_OFFSET, 32'h0);
        acc(1'b0, CLOCK_STATUS_OFFSET, 32'h0);
        chk({31'h0, rd[ST_SRC_SEL_BIT]}, 32'h1);
        $display("test registers done");
        repeat (40)
        begin
            @(posedge clk);
            chk({31'h0, uclk}, {31'h0, ext_clk});
            chk({31'h0, sclk}, {31'h0, uclk});
        end
        $display("test source done");
        for (int s = 0; s < 2; s++)
            for (int k = 0; k < 5; k++)
            begin
                sel <= s[0];
                acc(1'b1, CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET, k == 0 ? 32'h0 : 32'h1 << (k - 1));
                repeat (100) @(posedge clk);
                meas();
                chk(gap, (s ? 20 : 4) << (k == 0 ? 0 : k - 1));
                if (s == 1 && k > 1)
                    chk(hcnt, 20);
            end
        $display("test divide done");
        sel <= 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            // mux enable set for a multiplexed device
            acc(1'b1, CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET,
                ((c < 3 ? 32'h1 : 32'h0) << MUX_EN_BIT) | (32'(c[1:0]) << ADDR_CYC_LSB));
            cs_pulse();
            chk(ne, c < 3 ? c + 1 : 0);
            chk({31'h0, na != 0}, {31'h0, c < 3});
        end
        $display("test address phase done");
        wait_len <= 8'd30;
        for (int w = 0; w < 2; w++)
        begin
            acc(1'b1, CLOCK_DIVIDE_AND_MUX_CONTROL_OFFSET, 32'(w[0]) << WAIT_EN_BIT);
            cs_pulse();
            chk({31'h0, ns != 0}, w);
            chk({31'h0, stall}, 32'h0);
        end
        $display("test wait done");
        complete_run();
    end
endmodule
